// ### rtl/positioning_step_sequencer.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pss_params.svh"

module positioning_step_sequencer #(
	parameter int MS_CYCLES = `NS_PER_MS / `CLK_PERIOD_NS,
	parameter int CLK_HZ = `NS_PER_S / `CLK_PERIOD_NS
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic approach_sensor,
	input wire logic origin_in,
	output logic pulse_out,
	output logic dir_out,
	output logic busy,
	output logic out_disable
);
	import pss_pkg::*;

	pss_pkg::seq_s cur;
	pss_pkg::seq_s nxt;
	logic [95:0] tbl_rd;
	logic tbl_wr;

	function automatic logic [4:0] next_of(input logic [4:0] s, input logic rep,
		input logic [4:0] r);
		next_of = rep ? r : s + 5'h01;
	endfunction

	function automatic logic in_range(input logic [4:0] s);
		in_range = (s >= `STEP_MIN) && (s <= `STEP_MAX);
	endfunction

	assign tbl_wr = wr && (addr == `OFS_STEP_CTRL);

	step_table #(.DEPTH(`STEP_COUNT), .WIDTH(96)) step_table_inst (
		.clock(clock),
		.wr_en(tbl_wr),
		.wr_addr(cur.tsel - 5'h01),
		.wr_data({cur.tgoal, cur.tspeed, wdata}),
		.rd_addr(cur.step - 5'h01),
		.rd_data(tbl_rd)
	);

	assign rdata = cur.rdata;
	assign pulse_out = cur.pulse;
	assign dir_out = cur.dir;
	assign busy = cur.busy;
	assign out_disable = cur.out_dis;

	always_comb begin
		logic tick;
		logic [31:0] sum;
		logic [31:0] remain;
		logic [31:0] tgt;
		logic [31:0] newgoal;
		logic [4:0] ns;
		logic [4:0] req;
		logic cmd;
		logic can_start;
		logic appr_rise;
		logic appr_fall;
		logic org;
		logic [31:0] ctrl;
		tick = 1'b0;
		sum = '0;
		remain = '0;
		tgt = '0;
		newgoal = '0;
		ns = '0;
		req = '0;
		cmd = 1'b0;
		can_start = 1'b0;
		appr_rise = 1'b0;
		appr_fall = 1'b0;
		org = 1'b0;
		ctrl = tbl_rd[31:0];
		nxt = cur;
		nxt.pulse = 1'b0;

		// pins pass two flops; only the second stage is looked at
		nxt.appr_s1 = approach_sensor;
		nxt.appr_s2 = cur.appr_s1;
		nxt.org_s1 = origin_in;
		nxt.org_s2 = cur.org_s1;
		nxt.appr_prev = cur.appr_s2;
		appr_rise = cur.appr_s2 && !cur.appr_prev;
		appr_fall = !cur.appr_s2 && cur.appr_prev;
		org = cur.org_s2;

		// millisecond tick paces the ramp and the dwell
		if (cur.ms_cnt == 32'(MS_CYCLES - 1)) begin
			nxt.ms_cnt = '0;
			tick = 1'b1;
		end else begin
			nxt.ms_cnt = cur.ms_cnt + 32'h0000_0001;
		end

		// distance still to go toward the goal
		remain = cur.dir ? (cur.goal - cur.pos) : (cur.pos - cur.goal);

		// speed target for this cycle; decel when remaining fits the ramp
		tgt = cur.speed;
		if (cur.stopping) begin
			tgt = '0;
		end else if (cur.state == ST_MOVE && !cur.vel && cur.mode != MODE_CONT
			&& remain <= cur.brake) begin
			tgt = '0;
		end

		// ramp once per millisecond, never below bias except during a decelerating stop
		if (tick && (cur.state == ST_MOVE || cur.state == ST_HOME)) begin
			if (cur.spd + cur.accel < tgt) begin
				nxt.spd = cur.spd + cur.accel;
			end else if (cur.spd > tgt + cur.accel) begin
				nxt.spd = cur.spd - cur.accel;
			end else begin
				nxt.spd = tgt;
			end
			if (nxt.spd < `BIAS_PPS && !cur.stopping) begin
				nxt.spd = `BIAS_PPS;
			end
		end

		// track the section of the profile
		if (cur.state == ST_MOVE || cur.state == ST_HOME) begin
			if (tgt < cur.spd) begin
				nxt.sec = SEC_DEC;
			end else if (tgt > cur.spd) begin
				nxt.sec = SEC_ACC;
			end else begin
				nxt.sec = SEC_CONST;
			end
		end

		// pulse rate generator: phase accumulator in pulses per second
		if ((cur.state == ST_MOVE || cur.state == ST_HOME) && !cur.out_dis
			&& (cur.vel || cur.state == ST_HOME || remain != '0)) begin
			sum = cur.acc + cur.spd;
			if (sum >= 32'(CLK_HZ)) begin
				nxt.acc = sum - 32'(CLK_HZ);
				nxt.pulse = 1'b1;
				nxt.pos = cur.dir ? cur.pos + 32'h0000_0001 : cur.pos - 32'h0000_0001;
				if (cur.sec == SEC_ACC) begin
					nxt.brake = cur.brake + 32'h0000_0001; // pulses needed to brake
				end
			end else begin
				nxt.acc = sum;
			end
		end

		// register writes
		if (wr) begin
			unique case (addr)
				`OFS_DIRECT_GOAL: nxt.dgoal = wdata;
				`OFS_CMD_SPEED: nxt.cspeed = wdata;
				`OFS_ACCEL_RATE: nxt.accel = wdata;
				`OFS_HOME_CFG: nxt.hcfg = wdata[2:0];
				`OFS_HOME_HIGH: nxt.hhi = wdata;
				`OFS_HOME_LOW: nxt.hlo = wdata;
				`OFS_HOME_DWELL: nxt.hdwell = wdata[15:0];
				`OFS_STEP_SEL: nxt.tsel = wdata[4:0];
				`OFS_STEP_GOAL: nxt.tgoal = wdata;
				`OFS_STEP_SPEED: nxt.tspeed = wdata;
				default: nxt.tsel = nxt.tsel;
			endcase
		end

		// register reads, answered one cycle later
		nxt.rdata = '0;
		if (rd) begin
			unique case (addr)
				`OFS_DIRECT_GOAL: nxt.rdata = cur.dgoal;
				`OFS_CMD_SPEED: nxt.rdata = cur.cspeed;
				`OFS_ACCEL_RATE: nxt.rdata = cur.accel;
				`OFS_HOME_CFG: nxt.rdata = {29'h0, cur.hcfg};
				`OFS_HOME_HIGH: nxt.rdata = cur.hhi;
				`OFS_HOME_LOW: nxt.rdata = cur.hlo;
				`OFS_HOME_DWELL: nxt.rdata = {16'h0, cur.hdwell};
				`OFS_STEP_SEL: nxt.rdata = {27'h0, cur.tsel};
				`OFS_STEP_GOAL: nxt.rdata = cur.tgoal;
				`OFS_STEP_SPEED: nxt.rdata = cur.tspeed;
				`OFS_STATUS: nxt.rdata = {14'h0, cur.state == ST_HOME, 3'h0, cur.step, cur.done,
					cur.origin_set, cur.range_err, cur.dir_err, cur.out_dis, cur.estop_err,
					cur.sec, cur.busy};
				`OFS_POSITION: nxt.rdata = cur.pos;
				`OFS_SPEED_NOW: nxt.rdata = cur.spd;
				default: nxt.rdata = '0;
			endcase
		end

		cmd = wr && (addr == `OFS_CMD);
		can_start = cmd && cur.state == ST_IDLE && !cur.estop_err && !cur.out_dis;

		// error reset ahead of the sequencer and the halt, so any flag set this cycle wins
		if (cmd && wdata[`CMD_ERR_RESET]) begin
			nxt.estop_err = 1'b0;
			nxt.out_dis = 1'b0;
			nxt.dir_err = 1'b0;
			nxt.range_err = 1'b0;
		end

		// sequencer
		unique case (cur.state)
			ST_IDLE: begin
				nxt.sec = SEC_IDLE;
				nxt.spd = '0;
				nxt.stopping = 1'b0;
				if (can_start && wdata[`CMD_INDIRECT]) begin
					// zero selects the sequencer's own next step
					req = wdata[`CMD_STEP_LSB +: 5];
					if (req == 5'h00) begin
						req = cur.resume_valid ? cur.resume_step : `STEP_MIN;
					end
					if (in_range(req)) begin
						nxt.step = req;
						nxt.chain = 1'b0;
						nxt.done = 1'b0;
						nxt.resume_valid = 1'b0;
						nxt.state = ST_LOAD;
					end else begin
						nxt.range_err = 1'b1;
					end
				end else if (can_start && wdata[`CMD_DIRECT]) begin
					nxt.goal = cur.dgoal; // stored steps untouched
					nxt.speed = cur.cspeed;
					nxt.dir = $signed(cur.dgoal) >= $signed(cur.pos);
					nxt.mode = MODE_END;
					nxt.repeat_m = 1'b0;
					nxt.dwell = '0;
					nxt.vel = 1'b0;
					nxt.brake = '0;
					nxt.done = 1'b0;
					nxt.spd = `BIAS_PPS;
					nxt.state = ST_MOVE;
				end else if (can_start && wdata[`CMD_VELOCITY]) begin
					nxt.vel = 1'b1; // runs until a stop command
					nxt.dir = !wdata[`CMD_VEL_DIR];
					nxt.speed = cur.cspeed;
					nxt.spd = `BIAS_PPS;
					nxt.done = 1'b0;
					nxt.state = ST_MOVE;
				end else if (can_start && wdata[`CMD_HOMING]) begin
					nxt.state = ST_HOME;
					nxt.hph = HP_FAST;
					nxt.dir = cur.hcfg[2];
					nxt.speed = cur.hhi; // homing starts at the high speed
					nxt.spd = `BIAS_PPS;
					nxt.vel = 1'b0;
					nxt.done = 1'b0;
				end
			end
			ST_LOAD: nxt.state = ST_APPLY; // table read takes one cycle
			ST_APPLY: begin
				newgoal = ctrl[`CTRL_INCR] ? cur.pos + tbl_rd[95:64] : tbl_rd[95:64];
				nxt.goal = newgoal;
				nxt.speed = tbl_rd[63:32];
				nxt.mode = mode_e'(ctrl[`CTRL_MODE_LSB +: 2]);
				nxt.repeat_m = ctrl[`CTRL_REPEAT];
				nxt.rpt = ctrl[`CTRL_RPT_LSB +: 5];
				nxt.dwell = ctrl[`CTRL_DWELL_LSB +: 16];
				nxt.dir = $signed(newgoal) >= $signed(cur.pos);
				nxt.vel = 1'b0;
				nxt.state = ST_MOVE;
				if (!cur.chain) begin
					nxt.spd = `BIAS_PPS;
					nxt.brake = '0;
				end else if (nxt.dir != cur.dir) begin
					nxt.dir_err = 1'b1; // chained steps must keep direction
					nxt.state = ST_IDLE;
				end
			end
			ST_MOVE: begin
				if (cmd && wdata[`CMD_OVERRIDE] && cur.sec != SEC_DEC && !cur.stopping) begin
					nxt.speed = cur.cspeed;
				end
				if (cmd && wdata[`CMD_DECEL_STOP] && !cur.stopping) begin
					nxt.stopping = 1'b1;
					nxt.stop_sec = cur.sec;
				end else if (cur.stopping && cur.spd == '0) begin
					nxt.state = ST_IDLE;
					nxt.resume_valid = 1'b1;
					nxt.resume_step = (cur.stop_sec == SEC_DEC) ? cur.step + 5'h01 : cur.step;
				end else if (cmd && wdata[`CMD_NEXT_MOVE] && !cur.vel
					&& cur.mode == MODE_CONT && !cur.stopping) begin
					// any section may switch over at once
					ns = next_of(cur.step, cur.repeat_m, cur.rpt);
					if (in_range(ns)) begin
						nxt.step = ns;
						nxt.chain = 1'b1;
						nxt.state = ST_LOAD;
					end
				end else if (!cur.vel && remain == '0) begin
					ns = next_of(cur.step, cur.repeat_m, cur.rpt);
					if (cur.mode == MODE_CONT && in_range(ns)) begin
						nxt.step = ns; // keep speed, no ramp down
						nxt.chain = 1'b1;
						nxt.state = ST_LOAD;
					end else begin
						nxt.spd = '0;
						nxt.dwell_cnt = '0;
						nxt.state = ST_DWELL;
					end
				end
			end
			ST_DWELL: begin
				if (cur.dwell_cnt >= cur.dwell) begin
					nxt.done = 1'b1; // complete only after the dwell
					ns = next_of(cur.step, cur.repeat_m, cur.rpt);
					nxt.resume_step = ns;
					nxt.resume_valid = 1'b1;
					nxt.chain = 1'b0;
					if (cur.mode == MODE_KEEP && in_range(ns)) begin
						nxt.step = ns; // keep chains on by itself
						nxt.state = ST_LOAD;
					end else begin
						nxt.state = ST_IDLE; // end waits for a new start
					end
				end else if (tick) begin
					nxt.dwell_cnt = cur.dwell_cnt + 16'h0001;
				end
			end
			ST_HOME: begin
				// origin pin is only looked at here
				unique case (cur.hph)
					HP_FAST: begin
						if (appr_rise) begin
							if (home_method_e'(cur.hcfg[1:0]) == HM_APPROACH) begin
								nxt.pos = '0; // origin from approach alone
								nxt.origin_set = 1'b1;
								nxt.spd = '0;
								nxt.dwell = cur.hdwell;
								nxt.dwell_cnt = '0;
								nxt.mode = MODE_END;
								nxt.repeat_m = 1'b0;
								nxt.state = ST_DWELL;
							end else begin
								nxt.speed = cur.hlo;
								nxt.hph = HP_SLOW;
							end
						end
					end
					HP_SLOW: begin
						if (home_method_e'(cur.hcfg[1:0]) == HM_RELEASE) begin
							if (appr_fall) begin
								nxt.hph = HP_WAIT_OFF;
							end
						end else if (org && cur.spd <= cur.hlo) begin
							nxt.hph = HP_WAIT_OFF; // first origin at low speed
						end
					end
					default: begin
						if (org || home_method_e'(cur.hcfg[1:0]) == HM_ASSERT) begin
							nxt.pos = '0;
							nxt.origin_set = 1'b1;
							nxt.spd = '0;
							nxt.dwell = cur.hdwell;
							nxt.dwell_cnt = '0;
							nxt.mode = MODE_END;
							nxt.repeat_m = 1'b0;
							nxt.state = ST_DWELL;
						end
					end
				endcase
			end
			default: nxt.state = ST_IDLE;
		endcase

		if (cmd && wdata[`CMD_ESTOP]) begin
			nxt.estop_err = 1'b1;
			nxt.out_dis = 1'b1;
			nxt.spd = '0; // no ramp, pulse_out stays low from the next cycle on
			nxt.pulse = 1'b0;
			nxt.stopping = 1'b0;
			nxt.state = ST_IDLE;
		end
		nxt.busy = nxt.state != ST_IDLE;
	end

	// single state register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cur <= '0;
			cur.accel <= `RST_ACCEL_RATE;
			cur.hhi <= `RST_HOME_SPEED;
			cur.hlo <= `RST_HOME_SPEED;
		end else begin
			cur <= nxt;
		end
	end
endmodule

// ### rtl/pss_params.svh
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// register byte offsets
`define OFS_CMD 8'h00
`define OFS_DIRECT_GOAL 8'h04
`define OFS_CMD_SPEED 8'h08
`define OFS_ACCEL_RATE 8'h0C
`define OFS_HOME_CFG 8'h10
`define OFS_HOME_HIGH 8'h14
`define OFS_HOME_LOW 8'h18
`define OFS_HOME_DWELL 8'h1C
`define OFS_STEP_SEL 8'h20
`define OFS_STEP_GOAL 8'h24
`define OFS_STEP_SPEED 8'h28
`define OFS_STEP_CTRL 8'h2C
`define OFS_STATUS 8'h30
`define OFS_POSITION 8'h34
`define OFS_SPEED_NOW 8'h38

// command word bit positions
`define CMD_INDIRECT 0
`define CMD_DIRECT 1
`define CMD_VELOCITY 2
`define CMD_OVERRIDE 3
`define CMD_DECEL_STOP 4
`define CMD_ESTOP 5
`define CMD_ERR_RESET 6
`define CMD_HOMING 7
`define CMD_NEXT_MOVE 8
`define CMD_STEP_LSB 16
`define CMD_VEL_DIR 24

// step control word fields
`define CTRL_MODE_LSB 0
`define CTRL_REPEAT 2
`define CTRL_INCR 3
`define CTRL_RPT_LSB 4
`define CTRL_DWELL_LSB 16

// step number range and table size
`define STEP_MIN 5'h01
`define STEP_MAX 5'h14
`define STEP_COUNT 20

// reset values and the bias speed
`define RST_ACCEL_RATE 32'h0000_03E8
`define RST_HOME_SPEED 32'h0000_03E8
`define BIAS_PPS 32'h0000_0005

// timing
`define CLK_PERIOD_NS 20
`define NS_PER_MS 1000000
`define NS_PER_S 1000000000

`endif

// ### rtl/pss_pkg.sv
package pss_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_APPLY, ST_MOVE, ST_DWELL, ST_HOME} state_e;
	typedef enum logic [1:0] {SEC_IDLE, SEC_ACC, SEC_CONST, SEC_DEC} sec_e;
	typedef enum logic [1:0] {HP_FAST, HP_SLOW, HP_WAIT_OFF} home_e;
	typedef enum logic [1:0] {MODE_END, MODE_KEEP, MODE_CONT, MODE_RSVD} mode_e;
	typedef enum logic [1:0] {HM_RELEASE, HM_ASSERT, HM_APPROACH, HM_RSVD} home_method_e;

	typedef struct packed {
		state_e state;
		sec_e sec;
		sec_e stop_sec;
		home_e hph;
		logic [31:0] rdata;
		logic pulse;
		logic dir;
		logic busy;
		logic [31:0] pos;
		logic [31:0] goal;
		logic [31:0] speed;
		logic [31:0] spd;
		logic [31:0] acc;
		logic [31:0] brake;
		logic [31:0] ms_cnt;
		logic [15:0] dwell_cnt;
		logic [4:0] step;
		mode_e mode;
		logic repeat_m;
		logic [4:0] rpt;
		logic [15:0] dwell;
		logic chain;
		logic vel;
		logic stopping;
		logic [4:0] resume_step;
		logic resume_valid;
		logic estop_err;
		logic out_dis;
		logic dir_err;
		logic range_err;
		logic origin_set;
		logic done;
		logic [31:0] dgoal;
		logic [31:0] cspeed;
		logic [31:0] accel;
		logic [2:0] hcfg;
		logic [31:0] hhi;
		logic [31:0] hlo;
		logic [15:0] hdwell;
		logic [4:0] tsel;
		logic [31:0] tgoal;
		logic [31:0] tspeed;
		logic appr_s1;
		logic appr_s2;
		logic appr_prev;
		logic org_s1;
		logic org_s2;
	} seq_s;
endpackage

// ### rtl/step_table.sv
`timescale 1ns/1ps
// stored step parameters: one word per step, registered read
module step_table #(
	parameter int DEPTH = 20,
	parameter int WIDTH = 96
) (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [4:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// no reset on the array; software loads every step before use
	always_ff @(posedge clock) begin
		if (wr_en && (int'(wr_addr) < DEPTH)) begin
			mem[wr_addr] <= wr_data;
		end
		if (int'(rd_addr) < DEPTH) begin
			rd_data <= mem[rd_addr];
		end else begin
			rd_data <= '0;
		end
	end
endmodule

// ### test/motor_side_model.sv
`timescale 1ns/1ps
// motor driver plus sensors; cnt counts pulses since arm, in either direction
module motor_side_model (
	input wire logic clock,
	input wire logic pulse_out,
	input wire logic dir_out,
	input wire logic arm,
	output logic approach_sensor,
	output logic origin_in,
	output logic [31:0] pos,
	output logic [31:0] cnt
);
	initial begin
		pos = 32'h0;
		cnt = 32'h0;
	end
	// each step pulse moves the shaft one count
	always @(posedge clock) begin
		if (pulse_out)
			pos <= dir_out ? pos + 32'h1 : pos - 32'h1;
		cnt <= arm ? 32'h0 : cnt + {31'h0, pulse_out};
	end
	// cam spans counts 10..59; origin mark every eighth count, so homing is dir-agnostic
	assign approach_sensor = cnt >= 32'hA && cnt < 32'h3C;
	assign origin_in = cnt != 32'h0 && cnt[2:0] == 3'h0;
endmodule

// ### test/positioning_step_sequencer_chk.sv
`timescale 1ns/1ps
`include "pss_params.svh"
// pin-level watcher; command strobes are decoded here from the bus
module positioning_step_sequencer_chk (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic approach_sensor,
	input wire logic origin_in,
	input wire logic pulse_out,
	input wire logic dir_out,
	input wire logic busy,
	input wire logic out_disable
);
	logic cmd_wr;
	// one decode shared by every command property
	assign cmd_wr = wr && addr == `OFS_CMD;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_estop;
		cmd_wr && wdata[`CMD_ESTOP];
	endsequence
	sequence s_clear;
		out_disable && cmd_wr && wdata[`CMD_ERR_RESET] && !wdata[`CMD_ESTOP];
	endsequence
	sequence s_refused;
		out_disable && !busy && cmd_wr && wdata[`CMD_DIRECT];
	endsequence
	sequence s_start;
		!busy && !out_disable && cmd_wr && wdata[`CMD_DIRECT] && !wdata[`CMD_ESTOP];
	endsequence
	property p_rdata_idle;
		!rd |=> rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
	property p_unmapped;
		rd && addr == 8'hFC |=> rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_estop_cut;
		s_estop |=> !pulse_out [*4];
	endproperty
	a_estop_cut: assert property (p_estop_cut) else $error("pulses after halt");
	property p_estop_flags;
		s_estop |=> out_disable && !busy;
	endproperty
	a_estop_flags: assert property (p_estop_flags) else $error("halt flags missing");
	property p_refuse;
		s_refused |=> !busy;
	endproperty
	a_refuse: assert property (p_refuse) else $error("start while disabled");
	property p_err_reset;
		s_clear |=> !out_disable;
	endproperty
	a_err_reset: assert property (p_err_reset) else $error("disable not cleared");
	property p_flag_hold;
		out_disable && !(cmd_wr && wdata[`CMD_ERR_RESET]) |=> out_disable;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("disable dropped alone");
	property p_start;
		s_start |=> busy;
	endproperty
	a_start: assert property (p_start) else $error("direct start ignored");
	property p_quiet_idle;
		!busy [*2] |-> !pulse_out;
	endproperty
	a_quiet_idle: assert property (p_quiet_idle) else $error("pulse while idle");
	property p_dir_steady;
		busy && pulse_out ##1 busy |-> $stable(dir_out);
	endproperty
	a_dir_steady: assert property (p_dir_steady) else $error("direction changed mid move");
endmodule
bind positioning_step_sequencer positioning_step_sequencer_chk positioning_step_sequencer_chk_inst (
	.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .approach_sensor(approach_sensor), .origin_in(origin_in),
	.pulse_out(pulse_out), .dir_out(dir_out), .busy(busy), .out_disable(out_disable));

// ### test/positioning_step_sequencer_test.sv
`timescale 1ns/1ps
`include "pss_params.svh"
module positioning_step_sequencer_test;
	logic clock = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, arm = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, pos, cnt, got, last;
	logic approach_sensor, origin_in, pulse_out, dir_out, busy, out_disable;
	int num_errors = 0, num_checks = 0;
	always #10 clock = ~clock;
	// short ms tick and pulse divider keep every move to a few thousand cycles
	positioning_step_sequencer #(.MS_CYCLES(50), .CLK_HZ(1000)) positioning_step_sequencer_inst (
		.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .approach_sensor(approach_sensor), .origin_in(origin_in),
		.pulse_out(pulse_out), .dir_out(dir_out), .busy(busy), .out_disable(out_disable));
	motor_side_model motor_side_model_inst (.clock(clock), .pulse_out(pulse_out),
		.dir_out(dir_out), .arm(arm), .approach_sensor(approach_sensor),
		.origin_in(origin_in), .pos(pos), .cnt(cnt));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// data are taken just after the edge that follows the read strobe
	task automatic rreg(input logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rreg(a);
		chk(got, e);
	endtask
	task automatic step(input logic [4:0] n, input logic [31:0] g, input logic [31:0] c);
		wreg(`OFS_STEP_SEL, {27'h0, n});
		wreg(`OFS_STEP_GOAL, g);
		wreg(`OFS_STEP_SPEED, 32'h1F4);
		wreg(`OFS_STEP_CTRL, c);
	endtask
	// bounded wait, sampled on the falling edge to stay clear of updates
	task automatic wait_idle;
		repeat (3) @(negedge clock);
		for (int i = 0; i < 30000 && busy !== 1'b0; i++)
			@(negedge clock);
		chk({31'h0, busy}, 32'h0);
	endtask
	task automatic end_sim;
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#1000000;
		num_errors++;
		end_sim;
	end
	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rchk(`OFS_ACCEL_RATE, `RST_ACCEL_RATE);
		rchk(`OFS_HOME_LOW, `RST_HOME_SPEED);
		rchk(8'hFC, 32'h0);
		wreg(`OFS_DIRECT_GOAL, 32'h14);
		wreg(`OFS_CMD_SPEED, 32'h1F4);
		wreg(`OFS_CMD, 32'h2);
		wait_idle;
		chk(pos, 32'h14);
		// incremental: 1 continuous, 2 end, 3 end with repeat back to 1
		step(5'h01, 32'hA, 32'hA);
		step(5'h02, 32'hA, 32'h8);
		step(5'h03, 32'h5, 32'h1C);
		wreg(`OFS_CMD, 32'h0001_0001);
		wait_idle;
		chk(pos, 32'h28);
		wreg(`OFS_CMD, 32'h0003_0001);
		wait_idle;
		chk(pos, 32'h2D);
		wreg(`OFS_CMD, 32'h0000_0001);
		wait_idle;
		chk(pos, 32'h41);
		step(5'h04, 32'h5, 32'h9);
		step(5'h05, 32'h5, 32'h8);
		wreg(`OFS_CMD, 32'h0004_0001);
		wait_idle;
		chk(pos, 32'h4B);
		// continuous chain that reverses must flag an error
		step(5'h06, 32'h5, 32'hA);
		step(5'h07, 32'hFFFF_FFFB, 32'hA);
		wreg(`OFS_CMD, 32'h0006_0001);
		wait_idle;
		rreg(`OFS_STATUS);
		chk({31'h0, got[5]}, 32'h1);
		wreg(`OFS_CMD, 32'h0015_0001);
		rreg(`OFS_STATUS);
		chk({31'h0, got[6] & ~got[0]}, 32'h1);
		wreg(`OFS_CMD, 32'h40);
		// reverse velocity run, then emergency halt and refused restart
		wreg(`OFS_CMD_SPEED, 32'h12C);
		wreg(`OFS_CMD, 32'h0100_0004);
		repeat (100) @(negedge clock);
		chk({31'h0, dir_out}, 32'h0);
		last = pos;
		repeat (100) @(negedge clock);
		chk({31'h0, $signed(pos) < $signed(last)}, 32'h1);
		wreg(`OFS_CMD, 32'h20);
		@(negedge clock);
		chk({31'h0, out_disable}, 32'h1);
		last = pos;
		repeat (50) @(negedge clock);
		chk(pos, last);
		wreg(`OFS_CMD, 32'h2);
		repeat (2) @(negedge clock);
		chk({31'h0, busy}, 32'h0);
		wreg(`OFS_CMD, 32'h40);
		@(negedge clock);
		chk({31'h0, out_disable}, 32'h0);
		// slow ramp so the stop lands in the accelerating section
		wreg(`OFS_ACCEL_RATE, 32'hA);
		step(5'h08, 32'h200, 32'h0);
		step(5'h09, 32'h300, 32'h0);
		wreg(`OFS_CMD, 32'h0008_0001);
		repeat (300) @(negedge clock);
		rreg(`OFS_STATUS);
		chk({30'h0, got[2:1]}, 32'h1);
		wreg(`OFS_CMD, 32'h10);
		repeat (2) @(negedge clock);
		chk({31'h0, busy}, 32'h1);
		wait_idle;
		wreg(`OFS_ACCEL_RATE, `RST_ACCEL_RATE);
		wreg(`OFS_CMD, 32'h1);
		wait_idle;
		rchk(`OFS_POSITION, 32'h200);
		wreg(`OFS_HOME_HIGH, 32'hC8);
		wreg(`OFS_HOME_LOW, 32'h64);
		for (int m = 0; m < 3; m++) begin
			wreg(`OFS_HOME_CFG, m);
			@(posedge clock);
			arm <= 1'b1;
			@(posedge clock);
			arm <= 1'b0;
			wreg(`OFS_CMD, 32'h80);
			wait_idle;
			got = cnt & 32'hFFFF_FFFE;
			case (m)
				0: chk(got, 32'h40);
				1: chk({31'h0, got[2:0] == 3'h0 && got > 32'hA && got < 32'h3C}, 32'h1);
				default: chk(got, 32'hA);
			endcase
			rreg(`OFS_STATUS);
			chk({31'h0, got[7]}, 32'h1);
		end
		// origin marks keep passing during this move and must not disturb it
		wreg(`OFS_DIRECT_GOAL, 32'h40);
		wreg(`OFS_CMD, 32'h2);
		wait_idle;
		rchk(`OFS_POSITION, 32'h40);
		// continuous step cut short by next-move; without it the chain would reverse
		step(5'h0A, 32'h1000, 32'h2);
		step(5'h0B, 32'h60, 32'h0);
		wreg(`OFS_CMD, 32'h000A_0001);
		repeat (20) @(negedge clock);
		wreg(`OFS_CMD, 32'h100);
		wait_idle;
		rchk(`OFS_POSITION, 32'h60);
		// velocity run with override up, then down on a slow ramp so the stop lands in decel
		step(5'h0C, 32'h10, 32'h8);
		wreg(`OFS_CMD_SPEED, 32'h64);
		wreg(`OFS_CMD, 32'h4);
		repeat (60) @(negedge clock);
		rchk(`OFS_SPEED_NOW, 32'h64);
		wreg(`OFS_CMD_SPEED, 32'h190);
		wreg(`OFS_CMD, 32'h8);
		repeat (60) @(negedge clock);
		rchk(`OFS_SPEED_NOW, 32'h190);
		wreg(`OFS_ACCEL_RATE, 32'hA);
		wreg(`OFS_CMD_SPEED, 32'h64);
		wreg(`OFS_CMD, 32'h8);
		wreg(`OFS_CMD, 32'h10);
		wait_idle;
		wreg(`OFS_ACCEL_RATE, `RST_ACCEL_RATE);
		rreg(`OFS_POSITION);
		last = got;
		wreg(`OFS_CMD, 32'h1);
		wait_idle;
		rchk(`OFS_POSITION, last + 32'h10);
		end_sim;
	end
endmodule
